//--- fra_map.vh
// Register offsets, field positions, reset values and arrival codes
`ifndef FRA_MAP_VH
`define FRA_MAP_VH

// ******************************************************
// Register byte offsets
// ******************************************************
`define FRA_OFS_SELECT      8'h00
`define FRA_OFS_TARGET      8'h04
`define FRA_OFS_MAXFREQ     8'h08
`define FRA_OFS_THRESH_A    8'h0C
`define FRA_OFS_THRESH_B    8'h10
`define FRA_OFS_STATUS      8'h14

// ******************************************************
// Field positions
// ******************************************************
`define FRA_SEL_TERM11_LSB  0
`define FRA_SEL_TERM12_LSB  8
`define FRA_SEL_ALARM_LSB   16
`define FRA_TH_ACC_LSB      0
`define FRA_TH_DEC_LSB      16
`define FRA_ST_LEVEL_LSB    0
`define FRA_ST_RUN_BIT      3
`define FRA_ST_ACC_BIT      4
`define FRA_ST_DEC_BIT      5
`define FRA_ST_FREQ_LSB     16

// ******************************************************
// Reset values
// ******************************************************
`define FRA_RST_SELECT      24'h000000
`define FRA_RST_FREQ        16'h0000
`define FRA_RST_MAXFREQ     16'h0000

// ******************************************************
// Arrival function codes, one byte per terminal
// ******************************************************
`define FRA_CODE_NONE       8'h00
`define FRA_CODE_CONST      8'h01
`define FRA_CODE_OVER_A     8'h02
`define FRA_CODE_AT_A       8'h05
`define FRA_CODE_OVER_B     8'h18
`define FRA_CODE_AT_B       8'h19

// ******************************************************
// Hysteresis: 2.0 % of maximum frequency, in per mille
// ******************************************************
`define FRA_HYS_PERMIL      5'h14
`define FRA_PERMIL_DIV      21'h0003E8

`endif

//--- fra_arrival_eval.v
// One arrival comparator with its own hysteresis state for one output terminal
`timescale 1ns/100ps
`include "fra_map.vh"

module fra_arrival_eval (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Function selection
   input  wire [7:0]  code,
   // Frequencies and thresholds
   input  wire [15:0] freq,
   input  wire [15:0] target,
   input  wire [15:0] thAccA,
   input  wire [15:0] thDecA,
   input  wire [15:0] thAccB,
   input  wire [15:0] thDecB,
   input  wire [15:0] hys,
   // Drive state
   input  wire        runOn,
   input  wire        accel,
   input  wire        decel,
   // Terminal level
   output wire        levelOut
);

   reg        level_r;
   reg        level_nxt;
   reg  [7:0] code_r;
   reg [15:0] thAcc;
   reg [15:0] thDec;
   reg [15:0] thAt;
   reg [15:0] decLow;
   wire       ramp;

   assign ramp     = accel | decel;
   assign levelOut = level_r;

   // Distance between two frequencies, used by the constant-speed and set band checks
   function [15:0] absDiff;
      input [15:0] a;
      input [15:0] b;
      begin
         absDiff = (a >= b) ? (a - b) : (b - a);
      end
   endfunction

   // Pick threshold pair for the first or second family
   always @* begin
      thAcc = ((code == `FRA_CODE_OVER_B) || (code == `FRA_CODE_AT_B)) ? thAccB : thAccA;
      thDec = ((code == `FRA_CODE_OVER_B) || (code == `FRA_CODE_AT_B)) ? thDecB : thDecA;
      thAt  = decel ? thDec : thAcc;
      // Saturate so a low threshold never wraps the release point
      decLow = (thDec > hys) ? (thDec - hys) : 16'h0000;
   end

   // Next level: set on arrival, release beyond the hysteresis band or when forced off
   always @* begin
      level_nxt = level_r;
      case (code)
         `FRA_CODE_CONST: begin
            if (!runOn || ramp)
               level_nxt = 1'b0;
            else if (freq == target)
               level_nxt = 1'b1;
            else if (absDiff(freq, target) > hys)
               level_nxt = 1'b0;
         end
         `FRA_CODE_OVER_A, `FRA_CODE_OVER_B: begin
            if (!runOn && (code == `FRA_CODE_OVER_B))
               level_nxt = 1'b0;
            else if (freq >= thAcc)
               level_nxt = 1'b1;
            else if (freq < decLow)
               level_nxt = 1'b0;
         end
         `FRA_CODE_AT_A, `FRA_CODE_AT_B: begin
            if (!runOn && (code == `FRA_CODE_AT_B))
               level_nxt = 1'b0;
            else if (freq == thAt)
               level_nxt = 1'b1;
            else if (absDiff(freq, thAt) > hys)
               level_nxt = 1'b0;
         end
         default: begin
            level_nxt = 1'b0;
         end
      endcase
      // A new function starts from off so no stale level leaks across
      if (code != code_r)
         level_nxt = 1'b0;
   end

   // Level and last code register, updated every cycle
   always @(posedge clk) begin
      if (reset) begin
         level_r <= 1'b0;
         code_r  <= `FRA_CODE_NONE;
      end else begin
         level_r <= level_nxt;
         code_r  <= code;
      end
   end

endmodule

//--- fra_arrival_outputs.v
// Frequency arrival output terminals with APB register access
`timescale 1ns/100ps
`include "fra_map.vh"

module fra_arrival_outputs (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Drive state from the control core, same clock
   input  wire [15:0] outputFreq,
   input  wire        runActive,
   input  wire        accelActive,
   input  wire        decelActive,
   // Output terminals
   output wire        term11Out,
   output wire        term12Out,
   output wire        alarmRelayContact
);

   // ******************************************************
   // Declarations
   // ******************************************************
   reg  [23:0] select_r;
   reg  [15:0] target_r;
   reg  [15:0] maxFreq_r;
   reg  [15:0] thAccA_r;
   reg  [15:0] thDecA_r;
   reg  [15:0] thAccB_r;
   reg  [15:0] thDecB_r;
   reg  [15:0] hys_r;
   reg  [31:0] prdata_r;
   reg  [31:0] prdata_nxt;
   reg         pready_r;
   reg         pslverr_r;
   reg         pslverr_nxt;
   wire        accessPhase;
   wire        wrCommit;
   wire [20:0] hysProd;
   wire [20:0] hysQuot;
   wire [2:0]  levels;

   // ******************************************************
   // Address decode
   // ******************************************************

   // True for every offset that holds a register
   function isMapped;
      input [7:0] addr;
      begin
         case (addr)
            `FRA_OFS_SELECT,
            `FRA_OFS_TARGET,
            `FRA_OFS_MAXFREQ,
            `FRA_OFS_THRESH_A,
            `FRA_OFS_THRESH_B,
            `FRA_OFS_STATUS: isMapped = 1'b1;
            default:         isMapped = 1'b0;
         endcase
      end
   endfunction

   // Write strobe for one register offset; only a committed access phase counts
   function wrHit;
      input       commit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         wrHit = commit && (addr == ofs);
      end
   endfunction

   // One bus word from an accel/decel threshold pair, used by both pairs
   function [31:0] packPair;
      input [15:0] acc;
      input [15:0] dec;
      begin
         packPair                        = 32'h00000000;
         packPair[`FRA_TH_ACC_LSB +: 16] = acc;
         packPair[`FRA_TH_DEC_LSB +: 16] = dec;
      end
   endfunction

   // Status word; unused bits read as zero
   function [31:0] statusWord;
      input [2:0]  lvl;
      input        run;
      input        acc;
      input        dec;
      input [15:0] freq;
      begin
         statusWord                         = 32'h00000000;
         statusWord[`FRA_ST_LEVEL_LSB +: 3] = lvl;
         statusWord[`FRA_ST_RUN_BIT]        = run;
         statusWord[`FRA_ST_ACC_BIT]        = acc;
         statusWord[`FRA_ST_DEC_BIT]        = dec;
         statusWord[`FRA_ST_FREQ_LSB +: 16] = freq;
      end
   endfunction

   // ******************************************************
   // APB handshake
   // ******************************************************

   // One wait state: answer is registered so pready comes from a flop
   assign accessPhase = psel & penable;
   assign wrCommit    = accessPhase & pready_r & pwrite;
   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;

   // Read mux; status shows live comparator and drive state
   // Reads have no side effect, so a repeated read is harmless
   always @* begin
      prdata_nxt = 32'h00000000;
      case (paddr)
         `FRA_OFS_SELECT: begin
            prdata_nxt[23:0] = select_r;
         end
         `FRA_OFS_TARGET: begin
            prdata_nxt[15:0] = target_r;
         end
         `FRA_OFS_MAXFREQ: begin
            prdata_nxt[15:0] = maxFreq_r;
         end
         `FRA_OFS_THRESH_A: begin
            prdata_nxt = packPair(thAccA_r, thDecA_r);
         end
         `FRA_OFS_THRESH_B: begin
            prdata_nxt = packPair(thAccB_r, thDecB_r);
         end
         `FRA_OFS_STATUS: begin
            prdata_nxt = statusWord(levels, runActive, accelActive, decelActive, outputFreq);
         end
         default: begin
            prdata_nxt = 32'h00000000;
         end
      endcase
      // Unmapped offsets and writes to the status word are errors
      pslverr_nxt = !isMapped(paddr) || (pwrite && (paddr == `FRA_OFS_STATUS));
   end

   // Answer flops: pready pulses for one cycle in the second access cycle
   always @(posedge clk) begin
      if (reset) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= accessPhase & ~pready_r;
         if (accessPhase & ~pready_r) begin
            pslverr_r <= pslverr_nxt;
            prdata_r  <= pwrite ? 32'h00000000 : prdata_nxt;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // ******************************************************
   // Control registers
   // ******************************************************

   // Terminal function selection, one code byte per terminal
   always @(posedge clk) begin
      if (reset)
         select_r <= `FRA_RST_SELECT;
      else if (wrHit(wrCommit, paddr, `FRA_OFS_SELECT))
         select_r <= pwdata[23:0];
   end

   // Standard target frequency, reference of constant-speed mode
   always @(posedge clk) begin
      if (reset)
         target_r <= `FRA_RST_FREQ;
      else if (wrHit(wrCommit, paddr, `FRA_OFS_TARGET))
         target_r <= pwdata[15:0];
   end

   // Maximum frequency, scales the hysteresis band
   always @(posedge clk) begin
      if (reset)
         maxFreq_r <= `FRA_RST_MAXFREQ;
      else if (wrHit(wrCommit, paddr, `FRA_OFS_MAXFREQ))
         maxFreq_r <= pwdata[15:0];
   end

   // First threshold pair: accel on point and decel off point
   always @(posedge clk) begin
      if (reset) begin
         thAccA_r <= `FRA_RST_FREQ;
         thDecA_r <= `FRA_RST_FREQ;
      end else if (wrHit(wrCommit, paddr, `FRA_OFS_THRESH_A)) begin
         thAccA_r <= pwdata[`FRA_TH_ACC_LSB +: 16];
         thDecA_r <= pwdata[`FRA_TH_DEC_LSB +: 16];
      end
   end

   // Second threshold pair for the second over and set modes
   always @(posedge clk) begin
      if (reset) begin
         thAccB_r <= `FRA_RST_FREQ;
         thDecB_r <= `FRA_RST_FREQ;
      end else if (wrHit(wrCommit, paddr, `FRA_OFS_THRESH_B)) begin
         thAccB_r <= pwdata[`FRA_TH_ACC_LSB +: 16];
         thDecB_r <= pwdata[`FRA_TH_DEC_LSB +: 16];
      end
   end

   // ******************************************************
   // Hysteresis band
   // ******************************************************

   // Divided once and registered; a constant divider is cheap but slow,
   // so the band lags a new maximum by one cycle
   assign hysProd = maxFreq_r * `FRA_HYS_PERMIL;
   assign hysQuot = hysProd / `FRA_PERMIL_DIV;

   // Truncating: a maximum frequency below 50 leaves no band at all
   always @(posedge clk) begin
      if (reset)
         hys_r <= 16'h0000;
      else
         hys_r <= hysQuot[15:0];
   end

   // ******************************************************
   // Comparators, one per terminal
   // ******************************************************

   // Terminal 11 comparator; each terminal has its own code byte and hysteresis state
   fra_arrival_eval uEval11 (
      .clk      (clk),
      .reset    (reset),
      .code     (select_r[`FRA_SEL_TERM11_LSB +: 8]),
      .freq     (outputFreq),
      .target   (target_r),
      .thAccA   (thAccA_r),
      .thDecA   (thDecA_r),
      .thAccB   (thAccB_r),
      .thDecB   (thDecB_r),
      .hys      (hys_r),
      .runOn    (runActive),
      .accel    (accelActive),
      .decel    (decelActive),
      .levelOut (levels[0])
   );

   // Terminal 12 comparator
   fra_arrival_eval uEval12 (
      .clk      (clk),
      .reset    (reset),
      .code     (select_r[`FRA_SEL_TERM12_LSB +: 8]),
      .freq     (outputFreq),
      .target   (target_r),
      .thAccA   (thAccA_r),
      .thDecA   (thDecA_r),
      .thAccB   (thAccB_r),
      .thDecB   (thDecB_r),
      .hys      (hys_r),
      .runOn    (runActive),
      .accel    (accelActive),
      .decel    (decelActive),
      .levelOut (levels[1])
   );

   // Alarm relay comparator
   fra_arrival_eval uEvalAlarm (
      .clk      (clk),
      .reset    (reset),
      .code     (select_r[`FRA_SEL_ALARM_LSB +: 8]),
      .freq     (outputFreq),
      .target   (target_r),
      .thAccA   (thAccA_r),
      .thDecA   (thDecA_r),
      .thAccB   (thAccB_r),
      .thDecB   (thDecB_r),
      .hys      (hys_r),
      .runOn    (runActive),
      .accel    (accelActive),
      .decel    (decelActive),
      .levelOut (levels[2])
   );

   // Terminal pins come straight from the comparator level flops
   assign term11Out         = levels[0];
   assign term12Out         = levels[1];
   assign alarmRelayContact = levels[2];

endmodule

//--- fra_arrival_outputs_assertions.sv
// Checker for the arrival terminals and their register port
`timescale 1ns/100ps
`include "fra_map.vh"

module fra_arrival_checker (
   // Clock and reset
   input wire        clk,
   input wire        reset,
   // Register port
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Drive state
   input wire [15:0] outputFreq,
   input wire        runActive,
   input wire        accelActive,
   input wire        decelActive,
   // Terminals
   input wire        term11Out,
   input wire        term12Out,
   input wire        alarmRelayContact
);
   logic [7:0]  code11_r;
   logic [7:0]  code11Prev_r;
   logic [15:0] thA_r;
   logic [15:0] thB_r;
   wire         commitWr = psel && penable && pready && pwrite && !pslverr;
   wire         stable11 = code11Prev_r == code11_r;
   wire         rampOrStop = !runActive || accelActive || decelActive;
   wire         isB = code11_r == `FRA_CODE_OVER_B || code11_r == `FRA_CODE_AT_B;

   // ********************
   // Shadow state
   // ********************
   // The previous code hides the forced-off cycle that follows a code change
   always @(posedge clk) begin
      if (reset) begin
         code11_r     <= 8'h00;
         code11Prev_r <= 8'h00;
         thA_r        <= 16'h0000;
         thB_r        <= 16'h0000;
      end else begin
         code11Prev_r <= code11_r;
         if (commitWr && paddr == `FRA_OFS_SELECT) code11_r <= pwdata[7:0];
         if (commitWr && paddr == `FRA_OFS_THRESH_A) thA_r <= pwdata[15:0];
         if (commitWr && paddr == `FRA_OFS_THRESH_B) thB_r <= pwdata[15:0];
      end
   end

   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_reset_clear: assert property (disable iff (1'b0) reset |=> !term11Out && !term12Out && !alarmRelayContact)
      else $error("Terminal on after reset");
   a_const_off: assert property (code11_r == `FRA_CODE_CONST && rampOrStop |=> !term11Out)
      else $error("Constant speed level on while stopped or ramping");
   a_second_stop: assert property (isB && !runActive |=> !term11Out)
      else $error("Second mode level on while stopped");
   a_over_on: assert property (stable11 && code11_r == `FRA_CODE_OVER_B && runActive && outputFreq >= thB_r |=> term11Out)
      else $error("Over level off above accel threshold");
   a_at_on: assert property (stable11 && code11_r == `FRA_CODE_AT_A && !decelActive && outputFreq == thA_r |=> term11Out)
      else $error("Set level off at threshold");
   a_none_off: assert property (code11_r == `FRA_CODE_NONE |=> !term11Out)
      else $error("Unassigned terminal on");
   a_ready_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready)
      else $error("Ready not a single pulse after one wait state");
   a_status_ro: assert property (pready && pwrite && paddr == `FRA_OFS_STATUS |-> pslverr)
      else $error("Status write not refused");

   c_const_on: cover property (code11_r == `FRA_CODE_CONST && term11Out);
   c_refused: cover property (pready && pslverr);
   c_second_on: cover property (isB && term11Out);
endmodule

bind fra_arrival_outputs fra_arrival_checker i_chk (
   .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .outputFreq(outputFreq),
   .runActive(runActive), .accelActive(accelActive), .decelActive(decelActive),
   .term11Out(term11Out), .term12Out(term12Out), .alarmRelayContact(alarmRelayContact));

//--- fra_terminal_monitor.sv
// Controller and relay model that reads the three arrival terminals
`timescale 1ns/100ps

module fra_terminal_monitor (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Terminals
   input  wire        term11Out,
   input  wire        term12Out,
   input  wire        alarmRelayContact,
   // Observation
   output logic [7:0] relaySwitches,
   output logic [2:0] levelsSeen
);
   logic alarmLast_r;

   // Every relay switching wears the contact, so chatter shows up as extra counts
   always @(posedge clk) begin
      if (reset) begin
         relaySwitches <= 8'h00;
         alarmLast_r   <= 1'b0;
      end else begin
         alarmLast_r <= alarmRelayContact;
         if (alarmRelayContact !== alarmLast_r) relaySwitches <= relaySwitches + 8'h01;
      end
   end

   // Logic inputs latch the levels once per clock, one edge behind the terminals
   always @(posedge clk) levelsSeen <= {alarmRelayContact, term12Out, term11Out};
endmodule

//--- fra_arrival_outputs_test.sv
// Self-checking bench for the frequency arrival terminals
`timescale 1ns/100ps
`include "fra_map.vh"

module fra_arrival_outputs_test;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [15:0] outputFreq = 16'h0000;
   logic        runActive = 1'b0;
   logic        accelActive = 1'b0;
   logic        decelActive = 1'b0;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         term11Out;
   wire         term12Out;
   wire         alarmRelayContact;
   wire  [7:0]  relaySwitches;
   wire  [2:0]  levelsSeen;
   int          mismatches = 0;
   int          n_compared = 0;
   logic [31:0] rd;
   logic        err;

   always #20 clk = ~clk;

   fra_arrival_outputs i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .outputFreq(outputFreq), .runActive(runActive), .accelActive(accelActive), .decelActive(decelActive),
      .term11Out(term11Out), .term12Out(term12Out), .alarmRelayContact(alarmRelayContact));
   fra_terminal_monitor i_mon (.clk(clk), .reset(reset), .term11Out(term11Out), .term12Out(term12Out),
      .alarmRelayContact(alarmRelayContact), .relaySwitches(relaySwitches), .levelsSeen(levelsSeen));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One transfer; the request holds until ready is sampled, only the watchdog ends a dead wait
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Levels {alarm, term12, term11}; four edges cover the forced-off cycle and the monitor latch
   task automatic drive(input logic [15:0] f, input logic [2:0] rad, input logic [2:0] exp);
      outputFreq <= f;
      {runActive, accelActive, decelActive} <= rad;
      repeat (4) @(posedge clk);
      check({29'h0, levelsSeen}, {29'h0, exp});
   endtask

   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      apb(1'b0, `FRA_OFS_SELECT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check({rd[30:0], err}, 32'h1);
      apb(1'b1, `FRA_OFS_STATUS, 32'h1234);
      check({31'h0, err}, 32'h1);
      apb(1'b1, `FRA_OFS_MAXFREQ, 32'h000003E8);
      apb(1'b1, `FRA_OFS_TARGET, 32'hFFFF01F4);
      apb(1'b0, `FRA_OFS_TARGET, 32'h0);
      check(rd, 32'h000001F4);
      apb(1'b1, `FRA_OFS_THRESH_A, 32'h00C8012C);
      apb(1'b1, `FRA_OFS_SELECT, 32'h00010205);
      drive(16'h0000, 3'b000, 3'b000);
      drive(16'h012C, 3'b110, 3'b011);
      drive(16'h0136, 3'b110, 3'b011);
      drive(16'h0141, 3'b110, 3'b010);
      drive(16'h01F4, 3'b100, 3'b110);
      drive(16'h0203, 3'b100, 3'b110);
      drive(16'h0209, 3'b100, 3'b010);
      drive(16'h00CD, 3'b101, 3'b010);
      drive(16'h00B3, 3'b101, 3'b000);
      apb(1'b1, `FRA_OFS_THRESH_B, 32'h012C0190);
      apb(1'b1, `FRA_OFS_SELECT, 32'h00001918);
      drive(16'h0190, 3'b010, 3'b000);
      drive(16'h0190, 3'b110, 3'b011);
      drive(16'h012C, 3'b101, 3'b011);
      drive(16'h0117, 3'b101, 3'b000);
      apb(1'b1, `FRA_OFS_SELECT, 32'h00020501);
      drive(16'h012C, 3'b110, 3'b110);
      drive(16'h01F4, 3'b100, 3'b101);
      apb(1'b0, `FRA_OFS_STATUS, 32'h0);
      check({3'h0, rd[31:16], 10'h0, rd[5:3]}, {3'h0, 16'h01F4, 10'h0, 3'b001});
      check({24'h0, relaySwitches}, 32'h00000003);
      end_of_test;
   end

   // Watchdog well beyond the roughly 114 cycles the sequence needs
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      end_of_test;
   end
endmodule
